// [rtl/tirq_consts.svh]
// Constants of the timer and interrupt unit: offsets, fields, resets.
// Assumes a 32-bit AHB-Lite window, one aligned word per register.
`ifndef TIRQ_CONSTS_SVH
`define TIRQ_CONSTS_SVH
`define HI_RANGE     31:8
`define REGION_RANGE 7:5
`define FIELD_RANGE  4:2
`define REG_REGION   3'h0
`define TMR_FIRST    3'h1
`define TMR_LAST     3'h5
`define R_FLAGS_A    3'h0
`define R_FLAGS_B    3'h1
`define R_EN_A       3'h2
`define R_EN_B       3'h3
`define R_STATUS     3'h4
`define R_CFG        3'h5
`define R_GCTRL      3'h6
`define F_CTRL       3'h0
`define F_RLD_LO     3'h1
`define F_RLD_HI     3'h2
`define F_CNT_LO     3'h3
`define F_CNT_HI     3'h4
`define SC_BIT       7
`define FA_TX        0
`define FA_RX        1
`define FA_IDLE      2
`define FA_HI        3
`define FA_LO        4
`define FA_ERR       5
`define FA_SOF       6
`define FB_WAKE      4
`define FB_CARD      5
`define FB_ANY       6
`define ST_IRQ       0
`define ST_HI        1
`define ST_LO        2
`define CFG_THR      7:0
`define CFG_EXT      8
`define CFG_PIN      9
`define GC_RUN       0
`define GC_SSN       4
`define CTL_CLKSEL   1:0
`define CTL_AUTO     2
`define CTL_START    3
`define CTL_STOPEV   4
`define CTL_AUTOWAKE 5
`define CTL_STOP     6
`define CTL_RUN      7
`define CTRL_MASK    8'h37
`define CTRL_RST     8'h00
`define FLAG_RST     8'h00
`define THR_RST      8'h08
`define TMR_COUNT    5
`define GP_TMR       4
`define WAKE_IDX     4
`define DIV_MAX      6'h3f
`define FIFO_CW      10
`define FIFO_DEPTH   10'h200
`endif

// [rtl/tirq_pkg.sv]
// Types shared by the timer and interrupt unit.
// Assumes nothing of its surroundings.
package tirq_pkg;
    typedef enum logic [1:0] {src_carrier, src_div, src_wake} clk_src_t;
    typedef enum logic {pw_awake, pw_standby} power_state_t;
endpackage

// [rtl/timer_if.sv]
// Carrier between the unit's control logic and one timer channel.
// Assumes tick, start and stop are one-cycle pulses in the hclk domain.
interface timer_if #(
    parameter int W = 16
);
    logic         tick;
    logic         start;
    logic         stop;
    logic         auto_reload;
    logic [W-1:0] reload;
    logic [W-1:0] count;
    logic         running;
    logic         underflow;

    modport ctrl (output tick, start, stop, auto_reload, reload,
                  input count, running, underflow);
    modport chan (input tick, start, stop, auto_reload, reload,
                  output count, running, underflow);
endinterface

// [rtl/timer_channel.sv]
// One down-counting timer channel.
// Assumes its controller pulses tick at the selected count rate.
module timer_channel (
    input wire logic hclk,
    input wire logic hresetn,
    timer_if.chan    t
);
    wire at_zero = (t.count == '0);

    // ========================================================
    // Counter
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            t.count     <= '0;
            t.running   <= 1'b0;
            t.underflow <= 1'b0;
        end
        else
        begin
            t.underflow <= t.running & t.tick & at_zero & ~t.stop & ~t.start;
            if (t.stop)
                t.running <= 1'b0;
            else if (t.start)
            begin
                t.running <= 1'b1;
                t.count   <= t.reload;
            end
            else if (t.running & t.tick)
            begin
                if (at_zero)
                begin
                    if (t.auto_reload)
                        t.count <= t.reload;
                    else
                        t.running <= 1'b0;
                end
                else
                    t.count <= t.count - 1'b1;
            end
        end
    end
endmodule

// [rtl/timer_and_interrupt_unit.sv]
`include "tirq_consts.svh"
// Timer and interrupt unit: AHB-Lite slave, interrupt flags and enables,
// four general timers and a wake-up timer.
// Assumes all event inputs are synchronous to hclk; ticks are 1-cycle pulses.
module timer_and_interrupt_unit #(
    parameter int TW = 16
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic                 carrier_tick,
    input  wire logic                 lfo_tick,
    input  wire logic                 tx_eof_start,
    input  wire logic                 rx_end,
    input  wire logic                 cmd_idle,
    input  wire logic [`FIFO_CW-1:0]  fifo_count,
    input  wire logic [7:0]           rx_error,
    input  wire logic                 low_power_card_detection_mode,
    input  wire logic                 card_found,
    input  wire logic                 low_power_card_detection_done,
    input  wire logic                 rx_sof,
    input  wire logic [3:0]           timer_stop_event,
    output logic                      irq_out,
    output logic                      standby_req,
    output logic                      wake_up
);
    // ========================================================
    // Storage
    logic [7:0]                   intr_flags_a;
    logic [7:0]                   intr_flags_b;
    logic [7:0]                   intr_enable_a;
    logic [7:0]                   intr_enable_b;
    logic [7:0]                   fifo_threshold;
    logic                         fifo_threshold_ext;
    logic                         pin_enable;
    logic [7:0]                   tctrl [`TMR_COUNT];
    logic [TW-1:0]                treload [`TMR_COUNT];
    logic [TW-1:0]                cnt_v [`TMR_COUNT];
    logic [`TMR_COUNT-1:0]        run_v;
    logic [`TMR_COUNT-1:0]        uf_v;
    logic [`TMR_COUNT-1:0]        tstart;
    logic                         dph_wr;
    logic [7:0]                   dph_addr;
    logic [5:0]                   div_cnt;
    logic                         div_tick;
    tirq_pkg::power_state_t       pstate;
    tirq_pkg::power_state_t       next_pstate;

    // The set or clear choice in bit 7 is never stored, so bit 7 reads zero.
    function automatic logic [7:0] setclr(input logic [7:0] cur, input logic [31:0] wd);
        logic [7:0] m;
        m = {1'b0, wd[`SC_BIT-1:0]};
        setclr = wd[`SC_BIT] ? (cur | m) : (cur & ~m);
    endfunction

    // ========================================================
    // Bus address phase and read decode
    wire       addr_ok  = hsel & htrans[1] & hready;
    wire       r_map    = (haddr[`HI_RANGE] == '0);
    wire [2:0] r_reg    = haddr[`REGION_RANGE];
    wire [2:0] r_fld    = haddr[`FIELD_RANGE];
    wire [2:0] r_ti     = r_reg - `TMR_FIRST;
    wire       r_page   = r_map & (r_reg == `REG_REGION);
    wire       r_tmr    = r_map & (r_reg >= `TMR_FIRST) & (r_reg <= `TMR_LAST);

    wire [7:0] ena_hit  = intr_flags_a & intr_enable_a;
    wire [7:0] enb_hit  = intr_flags_b & intr_enable_b;
    wire       pending  = (|ena_hit[`SC_BIT-1:0]) | (|enb_hit[`FB_ANY-1:0]);
    wire       summary  = pending | enb_hit[`FB_ANY];

    wire [`FIFO_CW-1:0] free_cnt = `FIFO_DEPTH - fifo_count;
    wire       fifo_high_status = (free_cnt <= {1'b0, fifo_threshold_ext, fifo_threshold});
    wire       fifo_low_status  = (fifo_count <= {2'b00, fifo_threshold});

    wire [7:0] stat_v;
    assign stat_v[`ST_IRQ] = summary;
    assign stat_v[`ST_HI]  = fifo_high_status;
    assign stat_v[`ST_LO]  = fifo_low_status;
    assign stat_v[7:3]     = '0;

    wire [31:0] page_rd =
        (r_fld == `R_FLAGS_A) ? {24'h0, intr_flags_a} :
        (r_fld == `R_FLAGS_B) ? {24'h0, intr_flags_b} :
        (r_fld == `R_EN_A)    ? {24'h0, intr_enable_a} :
        (r_fld == `R_EN_B)    ? {24'h0, intr_enable_b} :
        (r_fld == `R_STATUS)  ? {24'h0, stat_v} :
        (r_fld == `R_CFG)     ? {22'h0, pin_enable, fifo_threshold_ext, fifo_threshold} :
        (r_fld == `R_GCTRL)   ? {28'h0, run_v[`GP_TMR-1:0]} : 32'h0;

    wire [31:0] tmr_rd =
        (r_fld == `F_CTRL)   ? {24'h0, run_v[r_ti], tctrl[r_ti][`CTL_RUN-1:0]} :
        (r_fld == `F_RLD_LO) ? {24'h0, treload[r_ti][7:0]} :
        (r_fld == `F_RLD_HI) ? {24'h0, treload[r_ti][TW-1:8]} :
        (r_fld == `F_CNT_LO) ? {24'h0, cnt_v[r_ti][7:0]} :
        (r_fld == `F_CNT_HI) ? {24'h0, cnt_v[r_ti][TW-1:8]} : 32'h0;

    wire [31:0] rd_mux = r_page ? page_rd : r_tmr ? tmr_rd : 32'h0;

    // Read data is captured at the address phase so that it stands from a
    // flip-flop in the data phase; the cost is that a read issued back to
    // back behind a write to the same register returns the old value.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            dph_wr    <= 1'b0;
            dph_addr  <= 8'h00;
        end
        else
        begin
            hrdata    <= (addr_ok & ~hwrite) ? rd_mux : 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            dph_wr    <= addr_ok & hwrite & r_map;
            if (addr_ok)
                dph_addr <= haddr[7:0];
        end
    end

    // ========================================================
    // Write decode (data phase)
    wire [2:0] w_reg   = dph_addr[`REGION_RANGE];
    wire [2:0] w_fld   = dph_addr[`FIELD_RANGE];
    wire [2:0] w_ti    = w_reg - `TMR_FIRST;
    wire       w_page  = dph_wr & (w_reg == `REG_REGION);
    wire       w_tmr   = dph_wr & (w_reg >= `TMR_FIRST) & (w_reg <= `TMR_LAST);
    wire       w_fa    = w_page & (w_fld == `R_FLAGS_A);
    wire       w_fb    = w_page & (w_fld == `R_FLAGS_B);
    wire       w_ea    = w_page & (w_fld == `R_EN_A);
    wire       w_eb    = w_page & (w_fld == `R_EN_B);
    wire       w_cfg   = w_page & (w_fld == `R_CFG);
    wire       w_gctl  = w_page & (w_fld == `R_GCTRL);

    // ========================================================
    // Hardware flag sources
    wire [7:0] hw_a;
    wire [7:0] hw_b;
    assign hw_a[`FA_TX]   = tx_eof_start;
    assign hw_a[`FA_RX]   = rx_end;
    assign hw_a[`FA_IDLE] = cmd_idle;
    assign hw_a[`FA_HI]   = fifo_high_status;
    assign hw_a[`FA_LO]   = fifo_low_status;
    assign hw_a[`FA_ERR]  = |rx_error;
    assign hw_a[`FA_SOF]  = rx_sof;
    assign hw_a[`SC_BIT]  = 1'b0;
    assign hw_b[`GP_TMR-1:0] = uf_v[`GP_TMR-1:0];
    assign hw_b[`FB_WAKE] = uf_v[`WAKE_IDX];
    assign hw_b[`FB_CARD] = card_found & low_power_card_detection_mode;
    assign hw_b[`FB_ANY]  = pending;
    assign hw_b[`SC_BIT]  = 1'b0;

    // set or clear by bit 7
    wire [7:0] sw_fa = w_fa ? setclr(intr_flags_a, hwdata) : intr_flags_a;
    wire [7:0] sw_fb = w_fb ? setclr(intr_flags_b, hwdata) : intr_flags_b;
    wire [7:0] next_flags_a = sw_fa | hw_a;
    wire [7:0] next_flags_b = sw_fb | hw_b;

    // ========================================================
    // Interrupt registers
    // flag and enable registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            intr_flags_a  <= `FLAG_RST;
            intr_flags_b  <= `FLAG_RST;
            intr_enable_a <= `FLAG_RST;
            intr_enable_b <= `FLAG_RST;
        end
        else
        begin
            intr_flags_a  <= next_flags_a;
            intr_flags_b  <= next_flags_b;
            intr_enable_a <= w_ea ? setclr(intr_enable_a, hwdata) : intr_enable_a;
            intr_enable_b <= w_eb ? setclr(intr_enable_b, hwdata) : intr_enable_b;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fifo_threshold     <= `THR_RST;
            fifo_threshold_ext <= 1'b0;
            pin_enable         <= 1'b0;
            irq_out            <= 1'b0;
        end
        else
        begin
            if (w_cfg)
            begin
                fifo_threshold     <= hwdata[`CFG_THR];
                fifo_threshold_ext <= hwdata[`CFG_EXT];
                pin_enable         <= hwdata[`CFG_PIN];
            end
            irq_out <= pin_enable & summary;
        end
    end

    // ========================================================
    // Timer configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < `TMR_COUNT; i++)
            begin
                tctrl[i]   <= `CTRL_RST;
                treload[i] <= '0;
            end
        end
        else if (w_tmr)
        begin
            if (w_fld == `F_CTRL)
                tctrl[w_ti] <= hwdata[7:0] & `CTRL_MASK;
            if (w_fld == `F_RLD_LO)
                treload[w_ti][7:0] <= hwdata[7:0];
            if (w_fld == `F_RLD_HI)
                treload[w_ti][TW-1:8] <= hwdata[TW-9:0];
        end
    end

    // The 212 kHz rate is the carrier tick divided by 64.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt  <= '0;
            div_tick <= 1'b0;
        end
        else
        begin
            div_tick <= carrier_tick & (div_cnt == `DIV_MAX);
            if (carrier_tick)
                div_cnt <= div_cnt + 1'b1;
        end
    end

    // ========================================================
    // Timer channels
    timer_if #(.W(TW)) tif [`TMR_COUNT] ();

    for (genvar g = 0; g < `TMR_COUNT; g++)
    begin : g_tmr
        wire ctl_wr = w_tmr & (w_fld == `F_CTRL) & (w_ti == 3'(g));
        wire gstart;
        wire gstop;
        wire ev_stop;
        if (g < `GP_TMR)
        begin : g_gp
            wire tirq_pkg::clk_src_t sel = tirq_pkg::clk_src_t'(tctrl[g][`CTL_CLKSEL]);
            assign gstart  = w_gctl & hwdata[`GC_SSN + g] & hwdata[`GC_RUN + g];
            assign gstop   = w_gctl & hwdata[`GC_SSN + g] & ~hwdata[`GC_RUN + g];
            assign ev_stop = timer_stop_event[g] & tctrl[g][`CTL_STOPEV];
            assign tif[g].tick = (sel == tirq_pkg::src_carrier) ? carrier_tick :
                                 (sel == tirq_pkg::src_div)     ? div_tick :
                                 (sel == tirq_pkg::src_wake)    ? uf_v[`WAKE_IDX] : 1'b0;
        end
        else
        begin : g_wake
            assign gstart  = 1'b0;
            assign gstop   = 1'b0;
            assign ev_stop = 1'b0;
            assign tif[g].tick = lfo_tick;
        end
        assign tstart[g]          = gstart | (ctl_wr & hwdata[`CTL_START]);
        assign tif[g].start       = tstart[g];
        assign tif[g].stop        = gstop | ev_stop | (ctl_wr & hwdata[`CTL_STOP]);
        assign tif[g].auto_reload = tctrl[g][`CTL_AUTO];
        assign tif[g].reload      = treload[g];
        assign cnt_v[g]           = tif[g].count;
        assign run_v[g]           = tif[g].running;
        assign uf_v[g]            = tif[g].underflow;

        timer_channel u_chan (
            .hclk    (hclk),
            .hresetn (hresetn),
            .t       (tif[g])
        );
    end

    // ========================================================
    // Wake-up and standby control
    wire wake_auto = tctrl[`WAKE_IDX][`CTL_AUTOWAKE];
    wire wake_rest = tctrl[`WAKE_IDX][`CTL_AUTO];
    wire no_card   = low_power_card_detection_done & ~card_found & wake_rest & run_v[`WAKE_IDX];
    // The control register still holds the old auto-wake bit during the starting write.
    wire wake_go   = tstart[`WAKE_IDX] & hwdata[`CTL_AUTOWAKE];

    always_comb
    begin
        next_pstate = pstate;
        unique case (pstate)
            tirq_pkg::pw_awake:
                if (wake_go | (wake_auto & no_card))
                    next_pstate = tirq_pkg::pw_standby;
            tirq_pkg::pw_standby:
                if (~wake_auto | uf_v[`WAKE_IDX])
                    next_pstate = tirq_pkg::pw_awake;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pstate      <= tirq_pkg::pw_awake;
            standby_req <= 1'b0;
            wake_up     <= 1'b0;
        end
        else
        begin
            pstate      <= next_pstate;
            standby_req <= (next_pstate == tirq_pkg::pw_standby);
            wake_up     <= uf_v[`WAKE_IDX] & (pstate == tirq_pkg::pw_standby);
        end
    end
endmodule

// [verif/tirq_asserts.sv]
// Checker of the bus answers and the interrupt pin of the timer unit.
// Assumes hready is the unit's own hreadyout, as with a single slave.
module tirq_asserts #(
    parameter int TW = 16
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input logic             hreadyout,
    input logic             hresp,
    input logic [31:0]      hrdata,
    input logic             irq_out
);
    // ==========
    // Helper logic
    logic       rd_ph;
    logic       wr_ph;
    logic [2:0] wr_age;
    assign rd_ph = hsel && htrans[1] && hready && !hwrite;
    assign wr_ph = hsel && htrans[1] && hready && hwrite;
    // Only a host write clears a flag, so the pin may fall only shortly after one.
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            wr_age <= 3'h7;
        else if (wr_ph)
            wr_age <= 3'h0;
        else if (wr_age != 3'h7)
            wr_age <= wr_age + 3'h1;
    // ==========
    // Properties
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_reg(logic [2:0] r);
        rd_ph && haddr[31:5] == 27'h0 && haddr[4:2] == r;
    endsequence
    sequence s_tmr(logic [2:0] f);
        rd_ph && haddr[31:8] == 24'h0 && haddr[7:5] != 3'h0 && haddr[7:5] <= 3'h5
        && haddr[4:2] == f;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus stall or error response");
    a_idle_data_zero: assert property (!rd_ph |=> hrdata == 32'h0)
        else $error("read data outside a read");
    a_unmapped_zero: assert property (rd_ph && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_flag_top_bit: assert property (rd_ph && haddr[31:4] == 28'h0 |=> hrdata[31:7] == 25'h0)
        else $error("flag or enable read above bit 6");
    a_status_width: assert property (s_reg(3'h4) |=> hrdata[31:3] == 29'h0)
        else $error("status read too wide");
    a_run_report: assert property (s_reg(3'h6) |=> hrdata[31:4] == 28'h0)
        else $error("running report too wide");
    a_count_bytes: assert property (s_tmr(3'h3) or s_tmr(3'h4) |=> hrdata[31:8] == 24'h0)
        else $error("count byte read too wide");
    a_ctrl_pulses: assert property (s_tmr(3'h0) |=> hrdata[31:8] == 24'h0 && !hrdata[3] && !hrdata[6])
        else $error("control read shows pulse bits");
    a_irq_sticky: assert property ($fell(irq_out) |-> wr_age <= 3'h4)
        else $error("interrupt pin fell without a write");
endmodule
bind timer_and_interrupt_unit tirq_asserts #(.TW(TW)) u_asserts (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .irq_out   (irq_out)
);

// [verif/timer_and_interrupt_unit_tb_top.sv]
// Self-checking bench of the timer and interrupt unit.
// Assumes the unit is the only slave; its hreadyout feeds hready.
module timer_and_interrupt_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [11:0] ev;
    logic [9:0]  fifo_count;
    logic [7:0]  rx_error;
    logic        low_power_card_detection_mode;
    logic        irq_out;
    logic        standby_req;
    logic        wake_up;
    logic        wake_seen;
    logic [31:0] r;
    logic [31:0] w;
    logic [7:0]  shadow [3];
    int          error_cnt;
    int          total_checks;
    int          seed;
    int          n;
    localparam logic [31:0] RA [9] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h14, 32'h18,
                                       32'h100, 32'h20, 32'h2c};
    localparam logic [31:0] RV [9] = '{0, 0, 0, 0, 32'h08, 0, 0, 0, 0};
    localparam logic [31:0] EVB [4] = '{32'h01, 32'h02, 32'h04, 32'h40};
    localparam logic [31:0] FC [4] = '{32'd9, 32'd8, 32'd503, 32'd504};
    localparam logic [31:0] FE [4] = '{32'h00, 32'h10, 32'h00, 32'h08};

    timer_and_interrupt_unit uut (
        .hclk             (hclk),
        .hresetn          (hresetn),
        .hsel             (hsel),
        .haddr            (haddr),
        .htrans           (htrans),
        .hwrite           (hwrite),
        .hsize            (3'h2),
        .hwdata           (hwdata),
        .hready           (hreadyout),
        .hreadyout        (hreadyout),
        .hresp            (hresp),
        .hrdata           (hrdata),
        .carrier_tick     (ev[4]),
        .lfo_tick         (ev[5]),
        .tx_eof_start     (ev[0]),
        .rx_end           (ev[1]),
        .cmd_idle         (ev[2]),
        .fifo_count       (fifo_count),
        .rx_error         (rx_error),
        .low_power_card_detection_mode        (low_power_card_detection_mode),
        .card_found       (ev[7]),
        .low_power_card_detection_done        (ev[6]),
        .rx_sof           (ev[3]),
        .timer_stop_event (ev[11:8]),
        .irq_out          (irq_out),
        .standby_req      (standby_req),
        .wake_up          (wake_up)
    );

    // ==========
    // Helpers
    function automatic logic [7:0] sc(input logic [7:0] o, input logic [7:0] v);
        return v[7] ? {1'b0, o[6:0] | v[6:0]} : {1'b0, o[6:0] & ~v[6:0]};
    endfunction
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e, input logic [31:0] a);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %0t at %h got %h exp %h", $time, a, g, e);
        end
    endtask
    // Samples on the falling edge, where hready and hrdata are settled for the next rise.
    task automatic wait_ready();
        int k;
        k = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && k < 50)
        begin
            @(negedge hclk);
            k++;
        end
        if (k >= 50)
        begin
            $display("ERROR %0t bus timeout", $time);
            error_cnt++;
            end_sim();
        end
        r = hrdata;
        @(posedge hclk);
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(r, e, a);
    endtask
    task automatic pulse(input int b);
        @(posedge hclk);
        ev[b] <= 1'b1;
        @(posedge hclk);
        ev[b] <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
    task automatic clear_all();
        wr(32'h08, 32'h7f);
        wr(32'h0c, 32'h7f);
        wr(32'h00, 32'h7f);
        wr(32'h04, 32'h7f);
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk)
        if (wake_up === 1'b1)
            wake_seen <= 1'b1;

    // ==========
    // Main sequence
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata, ev, rx_error, low_power_card_detection_mode, wake_seen} = '0;
        fifo_count = 10'h064;
        error_cnt = 0;
        total_checks = 0;
        seed = 67216;
        hresetn = 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (RA[i]) rdc(RA[i], RV[i]);
        shadow = '{8'h00, 8'h00, 8'h00};
        repeat (8)
        begin
            n = {$random(seed)} % 3;
            w = $random(seed) & 32'hff;
            shadow[n] = sc(shadow[n], w[7:0]);
            wr((n == 0) ? 32'h00 : 32'h04 + 32'(4 * n), w);
            rdc((n == 0) ? 32'h00 : 32'h04 + 32'(4 * n), {24'h0, shadow[n]});
        end
        clear_all();
        $display("done registers");
        for (int i = 0; i < 4; i++)
        begin
            pulse(i);
            rdc(32'h00, EVB[i]);
            wr(32'h00, 32'h7f);
        end
        rx_error <= 8'h01 << ({$random(seed)} % 8);
        repeat (2) @(posedge hclk);
        rx_error <= 8'h00;
        rdc(32'h00, 32'h20);
        for (int i = 0; i < 4; i++)
        begin
            fifo_count <= FC[i][9:0];
            repeat (2) @(posedge hclk);
            wr(32'h00, 32'h7f);
            rdc(32'h00, FE[i]);
        end
        fifo_count <= 10'h064;
        wr(32'h00, 32'h7f);
        pulse(7);
        rdc(32'h04, 32'h00);
        low_power_card_detection_mode <= 1'b1;
        pulse(7);
        rdc(32'h04, 32'h20);
        wr(32'h04, 32'h7f);
        $display("done events");
        wr(32'h08, 32'h81);
        wr(32'h14, 32'h208);
        pulse(0);
        rdc(32'h04, 32'h40);
        rdc(32'h10, 32'h01);
        check(irq_out, 1'b1, 32'hf0);
        clear_all();
        repeat (2) @(posedge hclk);
        check(irq_out, 1'b0, 32'hf0);
        pulse(1);
        rdc(32'h00, 32'h02);
        check(irq_out, 1'b0, 32'hf0);
        wr(32'h00, 32'h7f);
        $display("done interrupt");
        w = $random(seed);
        wr(32'h24, {24'h0, w[7:0]});
        wr(32'h28, {24'h0, w[15:8]});
        wr(32'h18, 32'h11);
        rdc(32'h2c, {24'h0, w[7:0]});
        rdc(32'h30, {24'h0, w[15:8]});
        wr(32'h18, 32'h10);
        rdc(32'h18, 32'h0);
        n = ({$random(seed)} % 14) + 2;
        wr(32'h24, 32'(n));
        wr(32'h28, 32'h0);
        wr(32'h18, 32'h11);
        rdc(32'h18, 32'h1);
        repeat (n / 2) pulse(4);
        rdc(32'h2c, 32'(n - n / 2));
        repeat (n - n / 2) pulse(4);
        rdc(32'h04, 32'h0);
        pulse(4);
        rdc(32'h04, 32'h1);
        rdc(32'h18, 32'h0);
        rdc(32'h2c, 32'h0);
        wr(32'h04, 32'h7f);
        wr(32'h20, 32'h04);
        wr(32'h20, 32'h0c);
        repeat (n + 1) pulse(4);
        rdc(32'h04, 32'h1);
        rdc(32'h2c, 32'(n));
        wr(32'h04, 32'h7f);
        repeat (n + 1) pulse(4);
        rdc(32'h04, 32'h1);
        wr(32'h18, 32'h10);
        rdc(32'h18, 32'h0);
        wr(32'h04, 32'h7f);
        wr(32'h20, 32'h10);
        wr(32'h18, 32'h11);
        repeat (2) pulse(4);
        pulse(8);
        rdc(32'h18, 32'h0);
        repeat (2) pulse(4);
        rdc(32'h2c, 32'(n - 2));
        rdc(32'h04, 32'h0);
        $display("done timers");
        wr(32'h60, 32'h02);
        wr(32'h18, 32'h44);
        wr(32'ha0, 32'h2c);
        repeat (2) @(posedge hclk);
        check(standby_req, 1'b1, 32'hf1);
        pulse(5);
        check(wake_seen, 1'b1, 32'hf2);
        check(standby_req, 1'b0, 32'hf1);
        rdc(32'h04, 32'h14);
        wr(32'h40, 32'h09);
        repeat (64) pulse(4);
        rdc(32'h04, 32'h16);
        pulse(6);
        check(standby_req, 1'b1, 32'hf1);
        wr(32'ha0, 32'h04);
        repeat (2) @(posedge hclk);
        check(standby_req, 1'b0, 32'hf1);
        $display("done wake");
        end_sim();
    end
endmodule
